// ### spi_pkg.sv
// Shared constants, register map and types of the SPI protocol unit
package spi_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] LINE_CTL_OFS = 8'h2C;
    localparam logic [7:0] PROT_CTL_OFS = 8'h5C;
    localparam logic [7:0] IRQ_EN_OFS = 8'h60;
    localparam logic [7:0] STATUS_OFS = 8'h64;
    localparam logic [7:0] CLEAR_OFS = 8'h68;
    localparam logic [7:0] TIMEOUT_OFS = 8'h6C;
    localparam logic [7:0] RX_DATA_OFS = 8'h70;
    localparam logic [7:0] TX_DATA_OFS = 8'h74;

    // ==========================================================
    // Field positions
    localparam int ROLE_BIT = 0;
    localparam int THREE_WIRE_BIT = 1;
    localparam int WL_LSB = 8;
    localparam int WL_MSB = 11;
    localparam int EV_SS_INACTIVE = 0;
    localparam int EV_SS_ACTIVE = 1;
    localparam int EV_TIMEOUT = 2;
    localparam int EV_BITCOUNT = 3;
    localparam int SS_LINE_BIT = 16;
    localparam int BUSY_BIT = 17;
    localparam int EV_W = 4;

    // ==========================================================
    // Synchroniser lanes
    localparam int SYNC_W = 4;
    localparam int PIN_SCLK = 0;
    localparam int PIN_SS_N = 1;
    localparam int PIN_MOSI = 2;
    localparam int PIN_MISO = 3;
    localparam logic [3:0] SYNC_RST = 4'h2;

    // ==========================================================
    // Values after reset
    localparam logic [3:0] IRQ_EN_RST = 4'h0;
    localparam logic [3:0] WL_RST = 4'h8;
    localparam logic [15:0] TIMEOUT_RST = 16'h0100;
    localparam logic [15:0] TX_DATA_RST = 16'h0000;

    // ==========================================================
    // Timing of the serial clock made in master role
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_HALF_NS = 80;
    localparam logic [3:0] SCLK_HALF_CYC = 4'(SCLK_HALF_NS / CLK_PERIOD_NS);

    // ==========================================================
    // Types
    typedef struct packed {
        logic three_wire_select;
        logic slave;
    } prot_ctl_t;

    localparam prot_ctl_t PROT_CTL_RST = '{three_wire_select: 1'b0, slave: 1'b0};

    typedef struct packed {
        logic bitcount;
        logic timeout;
        logic active;
        logic inactive;
    } event_t;

    typedef enum logic [1:0] {
        MST_IDLE = 2'b00,
        MST_LOW = 2'b01,
        MST_HIGH = 2'b10
    } mst_state_t;

endpackage

// ### pin_sync.sv
// Two-stage synchroniser for the serial pins, with a third stage for edge finding
`timescale 1ns/1ps
module pin_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [spi_pkg::SYNC_W-1:0] d_i,
    output logic [spi_pkg::SYNC_W-1:0] q_o,
    output logic [spi_pkg::SYNC_W-1:0] q_prev_o
);

    // ==========================================================
    // Stages
    // Only the second stage reads the first, to keep metastability contained
    logic [spi_pkg::SYNC_W-1:0] meta_reg;
    logic [spi_pkg::SYNC_W-1:0] sync_reg;
    logic [spi_pkg::SYNC_W-1:0] prev_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= spi_pkg::SYNC_RST;
            sync_reg <= spi_pkg::SYNC_RST;
            prev_reg <= spi_pkg::SYNC_RST;
        end else begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign q_o = sync_reg;
    assign q_prev_o = prev_reg;

endmodule

// ### spi_protocol_unit.sv
// SPI protocol unit: role and wire select, slave events, interrupt enables, Wishbone registers
//
// Notes on behaviour
// - Only in slave role a 3-wire link without slave select is supported.
// - Wire-count bit 1: 0 selects 4-wire, 1 selects 3-wire without slave select.
// - Slave flags bit-count error when time-out or select loss cuts a word short.
// - Enable bit 3 gates the bit-count error interrupt.
// - Enable bit 2 gates the slave time-out interrupt.
// - Enable bit 1 gates the slave-select-active interrupt.
// - Enable bit 0 gates the slave-select-inactive interrupt.
// - Interrupt enable register at 0x60 is read/write and resets to zero.
// - Internal slave select is active high for transition detection.
`timescale 1ns/1ps
module spi_protocol_unit (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_n_o,
    input wire logic ss_n_i,
    output logic ss_n_o,
    output logic ss_n_oe_n_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_n_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_n_o
);

    // ==========================================================
    // Helpers
    function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // A setting of zero stands for a full 16-bit word
    function automatic logic [4:0] word_len(input logic [3:0] setting);
        return (setting == 4'h0) ? 5'h10 : {1'b0, setting};
    endfunction

    // ==========================================================
    // Pin synchronisers
    logic [spi_pkg::SYNC_W-1:0] pin_s;
    logic [spi_pkg::SYNC_W-1:0] pin_p;

    pin_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({miso_i, mosi_i, ss_n_i, sclk_i}),
        .q_o(pin_s),
        .q_prev_o(pin_p)
    );

    // ==========================================================
    // State
    spi_pkg::prot_ctl_t prot_reg, prot_next;
    spi_pkg::event_t en_reg, en_next;
    spi_pkg::event_t status_reg, status_next;
    spi_pkg::mst_state_t mst_reg, mst_next;
    logic [3:0] word_length_setting_reg, word_length_setting_next;
    logic [15:0] timeout_reg, timeout_next;
    logic [15:0] to_cnt_reg, to_cnt_next;
    logic [15:0] tx_data_reg, tx_data_next;
    logic [15:0] rx_data_reg, rx_data_next;
    logic [15:0] tx_shift_reg, tx_shift_next;
    logic [15:0] rx_shift_reg, rx_shift_next;
    logic [4:0] bit_cnt_reg, bit_cnt_next;
    logic [3:0] half_cnt_reg, half_cnt_next;
    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic irq_reg, irq_next;
    logic sclk_reg, sclk_next;
    logic ss_n_reg, ss_n_next;
    logic mosi_reg, mosi_next;
    logic miso_reg, miso_next;
    logic master_oe_n_reg, master_oe_n_next;
    logic miso_oe_n_reg, miso_oe_n_next;

    // ==========================================================
    // Next-state logic
    always_comb begin
        logic req;
        logic ss_line;
        logic ss_line_prev;
        logic ss_act;
        logic sclk_rise;
        logic sclk_fall;
        logic [4:0] wl;
        logic [4:0] cnt_inc;
        logic [15:0] rx_base;
        logic [31:0] merged;
        spi_pkg::event_t ev;
        spi_pkg::event_t clear;
        logic [31:0] rd;
        req = 1'b0;
        ss_line = 1'b0;
        ss_line_prev = 1'b0;
        ss_act = 1'b0;
        sclk_rise = 1'b0;
        sclk_fall = 1'b0;
        wl = word_len(word_length_setting_reg);
        cnt_inc = bit_cnt_reg + 5'h01;
        rx_base = (bit_cnt_reg == 5'h00) ? 16'h0000 : rx_shift_reg;
        merged = 32'h0000_0000;
        ev = '0;
        clear = '0;
        rd = 32'h0000_0000;
        prot_next = prot_reg;
        en_next = en_reg;
        mst_next = mst_reg;
        word_length_setting_next = word_length_setting_reg;
        timeout_next = timeout_reg;
        to_cnt_next = to_cnt_reg;
        tx_data_next = tx_data_reg;
        rx_data_next = rx_data_reg;
        tx_shift_next = tx_shift_reg;
        rx_shift_next = rx_shift_reg;
        bit_cnt_next = bit_cnt_reg;
        half_cnt_next = half_cnt_reg;
        sclk_next = sclk_reg;
        ss_n_next = ss_n_reg;
        mosi_next = mosi_reg;
        miso_next = miso_reg;
        master_oe_n_next = master_oe_n_reg;
        miso_oe_n_next = miso_oe_n_reg;

        // Wishbone slave: one access taken per request, ack one cycle later
        req = wb_cyc_i & wb_stb_i & ~ack_reg;
        ack_next = req;
        dat_next = dat_reg;
        case (wb_adr_i)
            spi_pkg::LINE_CTL_OFS: begin
                rd[spi_pkg::WL_MSB:spi_pkg::WL_LSB] = word_length_setting_reg;
            end
            spi_pkg::PROT_CTL_OFS: begin
                rd[spi_pkg::THREE_WIRE_BIT] = prot_reg.three_wire_select;
                rd[spi_pkg::ROLE_BIT] = prot_reg.slave;
            end
            spi_pkg::IRQ_EN_OFS: begin
                rd[spi_pkg::EV_W-1:0] = en_reg;
            end
            spi_pkg::STATUS_OFS: begin
                rd[spi_pkg::EV_W-1:0] = status_reg;
                rd[spi_pkg::SS_LINE_BIT] = ~pin_s[spi_pkg::PIN_SS_N];
                rd[spi_pkg::BUSY_BIT] = (mst_reg != spi_pkg::MST_IDLE) | (bit_cnt_reg != 5'h00);
            end
            spi_pkg::TIMEOUT_OFS: begin
                rd[15:0] = timeout_reg;
            end
            spi_pkg::RX_DATA_OFS: begin
                rd[15:0] = rx_data_reg;
            end
            spi_pkg::TX_DATA_OFS: begin
                rd[15:0] = tx_data_reg;
            end
            default: begin
                rd = 32'h0000_0000;
            end
        endcase
        if (req & ~wb_we_i) begin
            dat_next = rd;
        end
        if (req & wb_we_i) begin
            merged = merge_sel(rd, wb_dat_i, wb_sel_i);
            case (wb_adr_i)
                spi_pkg::LINE_CTL_OFS: begin
                    word_length_setting_next = merged[spi_pkg::WL_MSB:spi_pkg::WL_LSB];
                end
                spi_pkg::PROT_CTL_OFS: begin
                    prot_next.slave = merged[spi_pkg::ROLE_BIT];
                    prot_next.three_wire_select = merged[spi_pkg::THREE_WIRE_BIT];
                end
                spi_pkg::IRQ_EN_OFS: begin
                    en_next = merged[spi_pkg::EV_W-1:0];
                end
                spi_pkg::CLEAR_OFS: begin
                    clear = wb_dat_i[spi_pkg::EV_W-1:0] & {spi_pkg::EV_W{wb_sel_i[0]}};
                end
                spi_pkg::TIMEOUT_OFS: begin
                    timeout_next = merged[15:0];
                end
                spi_pkg::TX_DATA_OFS: begin
                    tx_data_next = merged[15:0];
                end
                default: begin
                    clear = '0;
                end
            endcase
        end

        if (prot_reg.slave) begin
            // Slave role: the peer drives clock and select, we drive only miso
            master_oe_n_next = 1'b1;
            mst_next = spi_pkg::MST_IDLE;
            ss_line = ~pin_s[spi_pkg::PIN_SS_N];
            ss_line_prev = ~pin_p[spi_pkg::PIN_SS_N];
            ss_act = prot_reg.three_wire_select | ss_line;
            sclk_rise = pin_s[spi_pkg::PIN_SCLK] & ~pin_p[spi_pkg::PIN_SCLK];
            sclk_fall = ~pin_s[spi_pkg::PIN_SCLK] & pin_p[spi_pkg::PIN_SCLK];
            miso_oe_n_next = ~ss_act;
            if (~prot_reg.three_wire_select & ss_line & ~ss_line_prev) begin
                ev.active = 1'b1;
            end
            if (~prot_reg.three_wire_select & ~ss_line & ss_line_prev) begin
                ev.inactive = 1'b1;
                if (bit_cnt_reg != 5'h00) begin
                    ev.bitcount = 1'b1;
                end
                bit_cnt_next = 5'h00;
                to_cnt_next = 16'h0000;
            end else if (ss_act) begin
                if (sclk_rise) begin
                    to_cnt_next = 16'h0000;
                    rx_shift_next = {rx_base[14:0], pin_s[spi_pkg::PIN_MOSI]};
                    if (cnt_inc >= wl) begin
                        rx_data_next = rx_shift_next;
                        bit_cnt_next = 5'h00;
                    end else begin
                        bit_cnt_next = cnt_inc;
                    end
                end else if (sclk_fall) begin
                    if (bit_cnt_reg != 5'h00) begin
                        tx_shift_next = {tx_shift_reg[14:0], 1'b0};
                    end
                end else if (bit_cnt_reg != 5'h00 && timeout_reg != 16'h0000) begin
                    // A stalled word is abandoned so the next select starts cleanly
                    to_cnt_next = to_cnt_reg + 16'h0001;
                    if (to_cnt_next >= timeout_reg) begin
                        ev.timeout = 1'b1;
                        ev.bitcount = 1'b1;
                        bit_cnt_next = 5'h00;
                        to_cnt_next = 16'h0000;
                    end
                end
            end
            if (bit_cnt_next == 5'h00) begin
                tx_shift_next = tx_data_reg << (5'h10 - wl);
            end
            miso_next = tx_shift_next[15];
        end else begin
            // Master role: we make clock and select from our own clock
            master_oe_n_next = 1'b0;
            miso_oe_n_next = 1'b1;
            case (mst_reg)
                spi_pkg::MST_IDLE: begin
                    ss_n_next = 1'b1;
                    sclk_next = 1'b0;
                    bit_cnt_next = 5'h00;
                    if (req & wb_we_i & (wb_adr_i == spi_pkg::TX_DATA_OFS)) begin
                        tx_shift_next = tx_data_next << (5'h10 - wl);
                        mosi_next = tx_shift_next[15];
                        ss_n_next = 1'b0;
                        half_cnt_next = 4'h0;
                        mst_next = spi_pkg::MST_LOW;
                    end
                end
                spi_pkg::MST_LOW: begin
                    half_cnt_next = half_cnt_reg + 4'h1;
                    if (half_cnt_next >= spi_pkg::SCLK_HALF_CYC) begin
                        half_cnt_next = 4'h0;
                        sclk_next = 1'b1;
                        mst_next = spi_pkg::MST_HIGH;
                    end
                end
                spi_pkg::MST_HIGH: begin
                    half_cnt_next = half_cnt_reg + 4'h1;
                    if (half_cnt_next >= spi_pkg::SCLK_HALF_CYC) begin
                        half_cnt_next = 4'h0;
                        sclk_next = 1'b0;
                        rx_shift_next = {rx_base[14:0], pin_s[spi_pkg::PIN_MISO]};
                        if (cnt_inc >= wl) begin
                            rx_data_next = rx_shift_next;
                            bit_cnt_next = 5'h00;
                            ss_n_next = 1'b1;
                            mst_next = spi_pkg::MST_IDLE;
                        end else begin
                            bit_cnt_next = cnt_inc;
                            tx_shift_next = {tx_shift_reg[14:0], 1'b0};
                            mosi_next = tx_shift_next[15];
                            mst_next = spi_pkg::MST_LOW;
                        end
                    end
                end
                default: begin
                    mst_next = spi_pkg::MST_IDLE;
                end
            endcase
        end

        // Sticky flags: a new event wins over a clear in the same cycle
        status_next = (status_reg & ~clear) | ev;
        irq_next = |(status_reg & en_reg);
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prot_reg <= spi_pkg::PROT_CTL_RST;
            en_reg <= spi_pkg::IRQ_EN_RST;
            status_reg <= '0;
            mst_reg <= spi_pkg::MST_IDLE;
            word_length_setting_reg <= spi_pkg::WL_RST;
            timeout_reg <= spi_pkg::TIMEOUT_RST;
            to_cnt_reg <= 16'h0000;
            tx_data_reg <= spi_pkg::TX_DATA_RST;
            rx_data_reg <= 16'h0000;
            tx_shift_reg <= 16'h0000;
            rx_shift_reg <= 16'h0000;
            bit_cnt_reg <= 5'h00;
            half_cnt_reg <= 4'h0;
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
            sclk_reg <= 1'b0;
            ss_n_reg <= 1'b1;
            mosi_reg <= 1'b0;
            miso_reg <= 1'b0;
            master_oe_n_reg <= 1'b1;
            miso_oe_n_reg <= 1'b1;
        end else begin
            prot_reg <= prot_next;
            en_reg <= en_next;
            status_reg <= status_next;
            mst_reg <= mst_next;
            word_length_setting_reg <= word_length_setting_next;
            timeout_reg <= timeout_next;
            to_cnt_reg <= to_cnt_next;
            tx_data_reg <= tx_data_next;
            rx_data_reg <= rx_data_next;
            tx_shift_reg <= tx_shift_next;
            rx_shift_reg <= rx_shift_next;
            bit_cnt_reg <= bit_cnt_next;
            half_cnt_reg <= half_cnt_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
            irq_reg <= irq_next;
            sclk_reg <= sclk_next;
            ss_n_reg <= ss_n_next;
            mosi_reg <= mosi_next;
            miso_reg <= miso_next;
            master_oe_n_reg <= master_oe_n_next;
            miso_oe_n_reg <= miso_oe_n_next;
        end
    end

    // ==========================================================
    // Outputs
    assign wb_dat_o = dat_reg;
    assign wb_ack_o = ack_reg;
    assign irq_o = irq_reg;
    assign sclk_o = sclk_reg;
    assign sclk_oe_n_o = master_oe_n_reg;
    assign ss_n_o = ss_n_reg;
    assign ss_n_oe_n_o = master_oe_n_reg;
    assign mosi_o = mosi_reg;
    assign mosi_oe_n_o = master_oe_n_reg;
    assign miso_o = miso_reg;
    assign miso_oe_n_o = miso_oe_n_reg;

endmodule

// ### spi_master_model.sv
// External SPI master model driving the serial pins in mode 0
`timescale 1ns/1ps
module spi_master_model (
    output logic sclk_o,
    output logic ss_n_o,
    output logic mosi_o
);
    // ==========================================
    // Idle: clock stands low, select pulled high
    initial begin
        sclk_o = 1'b0;
        ss_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    task automatic xfer(input logic [15:0] d, input int n, input bit sel, input bit drop);
        #203;
        if (sel) ss_n_o = 1'b0;
        #200;
        for (int i = n - 1; i >= 0; i--) begin
            mosi_o = d[i];
            #80 sclk_o = 1'b1;
            #80 sclk_o = 1'b0;
        end
        // Released line shows the inverse
        mosi_o = ~mosi_o;
        #200;
        if (drop) ss_n_o = 1'b1;
        #200;
    endtask
endmodule

// ### spi_protocol_unit_assertions.sv
// Port checker for the SPI protocol unit
`timescale 1ns/1ps
module spi_protocol_unit_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq_o,
    input wire logic ss_n_i,
    input wire logic sclk_oe_n_o,
    input wire logic ss_n_oe_n_o,
    input wire logic mosi_oe_n_o,
    input wire logic miso_oe_n_o
);
    // ==========================================
    // Shadows of enables and role
    logic take;
    logic [3:0] ien_sh;
    logic [1:0] prot_sh;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ien_sh <= 4'h0;
            prot_sh <= 2'h0;
        end else if (take && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == spi_pkg::IRQ_EN_OFS) ien_sh <= wb_dat_i[3:0];
            if (wb_adr_i == spi_pkg::PROT_CTL_OFS) prot_sh <= wb_dat_i[1:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================
    // Properties
    property p_ack_next; take |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_ien_read;
        wb_ack_o && !wb_we_i && wb_adr_i == spi_pkg::IRQ_EN_OFS |-> wb_dat_o == {28'h0, ien_sh};
    endproperty
    a_ien_read: assert property (p_ien_read) else $error("enable readback wrong");
    property p_unmapped; wb_ack_o && !wb_we_i && wb_adr_i == 8'hF0 |-> wb_dat_o == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // One cycle lag behind the role register
    property p_role_oe;
        !$past(rst_i) |-> sclk_oe_n_o == $past(prot_sh[0]) && mosi_oe_n_o == sclk_oe_n_o
            && ss_n_oe_n_o == sclk_oe_n_o;
    endproperty
    a_role_oe: assert property (p_role_oe) else $error("pin enables disagree with role");
    property p_miso_oe; !sclk_oe_n_o |-> miso_oe_n_o; endproperty
    a_miso_oe: assert property (p_miso_oe) else $error("miso driven in master role");
    property p_irq_off; ien_sh == 4'h0 && $past(ien_sh) == 4'h0 |-> !irq_o; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq with all enables off");
    property p_irq_hold; irq_o && !(take && wb_we_i) && !$past(take && wb_we_i) |=> irq_o; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without a write");
    property p_ss_act; $fell(ss_n_i) && prot_sh == 2'b01 && ien_sh[1] |-> ##[1:8] irq_o; endproperty
    a_ss_act: assert property (p_ss_act) else $error("no irq on select active");
    property p_ss_inact; $rose(ss_n_i) && prot_sh == 2'b01 && ien_sh[0] |-> ##[1:8] irq_o; endproperty
    a_ss_inact: assert property (p_ss_inact) else $error("no irq on select inactive");
    c_irq: cover property ($rose(irq_o));
    c_sel: cover property ($fell(ss_n_i) && prot_sh == 2'b01);
    c_tx: cover property (take && wb_we_i && wb_adr_i == spi_pkg::TX_DATA_OFS);
endmodule
bind spi_protocol_unit spi_protocol_unit_assertions spi_protocol_unit_assertions_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .ss_n_i(ss_n_i), .sclk_oe_n_o(sclk_oe_n_o),
    .ss_n_oe_n_o(ss_n_oe_n_o), .mosi_oe_n_o(mosi_oe_n_o), .miso_oe_n_o(miso_oe_n_o));

// ### spi_protocol_unit_bench.sv
// Self-checking bench for the SPI protocol unit
`timescale 1ns/1ps
module spi_protocol_unit_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, q;
    logic wb_ack_o, irq_o, sclk_o, sclk_oe_n_o, ss_n_o, ss_n_oe_n_o;
    logic mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o, m_sclk, m_ss_n, m_mosi;
    logic sclk_w, ss_n_w, mosi_w, miso_w;
    int fails = 0;
    int compares = 0;
    int k;
    // ==========================================
    // Wires; miso loops mosi back in master role
    assign sclk_w = sclk_oe_n_o ? m_sclk : sclk_o;
    assign ss_n_w = ss_n_oe_n_o ? m_ss_n : ss_n_o;
    assign mosi_w = mosi_oe_n_o ? m_mosi : mosi_o;
    assign miso_w = miso_oe_n_o ? mosi_w : miso_o;
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    spi_protocol_unit spi_protocol_unit_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
        .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe_n_o(sclk_oe_n_o), .ss_n_i(ss_n_w), .ss_n_o(ss_n_o),
        .ss_n_oe_n_o(ss_n_oe_n_o), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n_o),
        .miso_i(miso_w), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o));
    spi_master_model spi_master_model_inst (.sclk_o(m_sclk), .ss_n_o(m_ss_n), .mosi_o(m_mosi));
    // ==========================================
    // Bus and compare tasks
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            $display("mismatch %0t no ack", $time);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string w);
        wb(1'b0, a, 32'h0);
        chk(q & m, e, w);
    endtask
    task automatic irqchk(input logic e);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, {31'h0, e}, "irq level");
    endtask
    task automatic finish_test();
        if (fails == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        $display("mismatch %0t watchdog", $time);
        finish_test();
    end
    // ==========================================
    // Scenarios
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(spi_pkg::IRQ_EN_OFS, 32'hFFFFFFFF, 32'h0, "enable reset");
        rd(spi_pkg::PROT_CTL_OFS, 32'h3, 32'h0, "role reset");
        chk({31'h0, sclk_oe_n_o}, 32'h0, "master drives clock");
        wr(spi_pkg::IRQ_EN_OFS, 32'hFFFFFFFF);
        rd(spi_pkg::IRQ_EN_OFS, 32'hFFFFFFFF, 32'hF, "enable rw");
        rd(8'hF0, 32'hFFFFFFFF, 32'h0, "unmapped");
        wr(spi_pkg::IRQ_EN_OFS, 32'h0);
        wr(spi_pkg::PROT_CTL_OFS, 32'h1);
        wr(spi_pkg::CLEAR_OFS, 32'hF);
        spi_master_model_inst.xfer(16'h00A5, 8, 1'b1, 1'b1);
        rd(spi_pkg::STATUS_OFS, 32'hF, 32'h3, "select events");
        irqchk(1'b0);
        rd(spi_pkg::RX_DATA_OFS, 32'hFFFF, 32'hA5, "slave word");
        wr(spi_pkg::IRQ_EN_OFS, 32'h2);
        irqchk(1'b1);
        wr(spi_pkg::IRQ_EN_OFS, 32'h1);
        irqchk(1'b1);
        wr(spi_pkg::CLEAR_OFS, 32'hF);
        irqchk(1'b0);
        // Word cut short by select loss
        wr(spi_pkg::IRQ_EN_OFS, 32'h3);
        spi_master_model_inst.xfer(16'h0005, 3, 1'b1, 1'b1);
        rd(spi_pkg::STATUS_OFS, 32'hF, 32'hB, "short word");
        wr(spi_pkg::IRQ_EN_OFS, 32'h8);
        irqchk(1'b1);
        wr(spi_pkg::IRQ_EN_OFS, 32'h4);
        irqchk(1'b0);
        wr(spi_pkg::CLEAR_OFS, 32'hF);
        // Time-out, select held
        wr(spi_pkg::TIMEOUT_OFS, 32'h20);
        spi_master_model_inst.xfer(16'h0005, 3, 1'b1, 1'b0);
        repeat (40) @(posedge clk_i);
        rd(spi_pkg::STATUS_OFS, 32'hF, 32'hE, "timeout");
        irqchk(1'b1);
        spi_master_model_inst.xfer(16'h0000, 0, 1'b1, 1'b1);
        wr(spi_pkg::CLEAR_OFS, 32'hF);
        // Three-wire slave: select never asserted
        wr(spi_pkg::PROT_CTL_OFS, 32'h3);
        wr(spi_pkg::TX_DATA_OFS, 32'h80);
        spi_master_model_inst.xfer(16'h003C, 8, 1'b0, 1'b0);
        rd(spi_pkg::STATUS_OFS, 32'h3, 32'h0, "no select events");
        rd(spi_pkg::RX_DATA_OFS, 32'hFFFF, 32'h3C, "three-wire word");
        chk({31'h0, miso_o}, 32'h1, "miso first bit");
        // Master role, data looped back through the wire
        wr(spi_pkg::PROT_CTL_OFS, 32'h0);
        wr(spi_pkg::TX_DATA_OFS, 32'h96);
        chk({31'h0, ss_n_o}, 32'h0, "select out");
        k = 0;
        do begin
            wb(1'b0, spi_pkg::STATUS_OFS, 32'h0);
            k |= sclk_o;
        end while (q[spi_pkg::BUSY_BIT] !== 1'b0);
        chk(k, 32'h1, "clock out");
        rd(spi_pkg::RX_DATA_OFS, 32'hFF, 32'h96, "master word");
        finish_test();
    end
endmodule
